/* File: hdl/spof_formatter.sv */
// Sensor pixel output formatter: row/frame timing, decimation, sync and bus.
// Assumes raw_pixel carries the array sample of the current slot each clock.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module spof_formatter (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] raw_pixel,
    output logic [11:0] pixel_bus,
    output logic line_sync,
    output logic frame_sync,
    output logic pixel_strobe,
    output logic [1:0] pixel_colour
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [12:0] slot;
        logic [12:0] row;
        logic [11:0] frame_cnt;
        logic [11:0] pixel_bus;
        logic line_sync;
        logic frame_sync;
        logic pixel_strobe;
        logic [1:0] colour;
    } spof_fmt_state_t;

    spof_fmt_state_t st_r;
    spof_fmt_state_t st_nxt;
    spof_pkg::spof_cfg_t cfg;
    spof_pkg::spof_status_t status;

    logic [12:0] line_len;
    logic [12:0] frame_len;
    logic [12:0] img_end;
    logic [11:0] col;
    logic [12:0] hpos;
    logic slot_last;
    logic row_last;
    logic in_dark;
    logic in_array;
    logic in_line_blank_interval;
    logic row_active;
    logic col_border;
    logic row_border;
    logic col_ok;
    logic row_ok;
    logic col_keep;
    logic row_keep;
    logic row_out;
    logic pix_valid;
    logic dark_valid;
    logic valid;
    logic sync_end;
    logic sync_start;
    logic [1:0] sync_idx;
    logic [7:0] sync_word;
    logic [7:0] pix8;
    logic [11:0] bus_val;
    logic line_lvl;
    logic frame_lvl;
    logic strobe_lvl;
    logic [3:0] col_period;
    logic [3:0] row_period;
    logic last_active;
    logic next_active;
    logic col_odd;
    logic [1:0] colour_val;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    spof_apb_regs u_regs (
        .clk(clk),
        .rstn(rstn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status(status),
        .cfg(cfg)
    );

    // ------------------------------------------------------------------
    // Decimators
    // ------------------------------------------------------------------
    // Binning skips the pairs it would combine; subsampling applies without it
    // A period of 0 or 1 keeps every pair
    always_comb begin
        if (cfg.bin_col > 3'd1) begin
            col_period = {1'b0, cfg.bin_col};
        end else begin
            col_period = cfg.sub_col;
        end
        if (cfg.bin_row > 3'd1) begin
            row_period = {1'b0, cfg.bin_row};
        end else begin
            row_period = cfg.sub_row;
        end
    end

    spof_pair_keep u_col_keep (
        .clk(clk),
        .rstn(rstn),
        .restart(slot_last),
        .step(in_array),
        .period(col_period),
        .keep(col_keep)
    );

    spof_pair_keep u_row_keep (
        .clk(clk),
        .rstn(rstn),
        .restart(slot_last & row_last),
        .step(slot_last & row_active),
        .period(row_period),
        .keep(row_keep)
    );

    // ------------------------------------------------------------------
    // Slot decode
    // ------------------------------------------------------------------
    always_comb begin
        line_len = spof_pkg::SPOF_DARK_SLOTS + {1'b0, cfg.cols} + {1'b0, cfg.line_blank_interval};
        frame_len = {1'b0, cfg.rows} + {1'b0, cfg.frame_blank_rows};
        img_end = spof_pkg::SPOF_DARK_SLOTS + {1'b0, cfg.cols};
        slot_last = (st_r.slot == line_len - 13'd1);
        row_last = (st_r.row == frame_len - 13'd1);
        in_dark = (st_r.slot < spof_pkg::SPOF_DARK_SLOTS);
        in_array = !in_dark && (st_r.slot < img_end);
        in_line_blank_interval = !in_dark && !in_array;
        col = 12'(st_r.slot - spof_pkg::SPOF_DARK_SLOTS);
        hpos = st_r.slot - img_end;
        row_active = (st_r.row < {1'b0, cfg.rows});
        // Arrays under two borders wide count as border throughout
        col_border = (col < spof_pkg::SPOF_BORDER) || (col >= cfg.cols - spof_pkg::SPOF_BORDER);
        row_border = (st_r.row[11:0] < spof_pkg::SPOF_BORDER) ||
                     (st_r.row[11:0] >= cfg.rows - spof_pkg::SPOF_BORDER);
        col_ok = cfg.all_phys || !col_border;
        row_ok = cfg.all_phys || cfg.black_rows || !row_border;
        row_out = row_active && row_ok && row_keep;
        pix_valid = row_out && in_array && col_ok && col_keep;
        dark_valid = row_out && in_dark && cfg.dark_out;
        valid = pix_valid || dark_valid;
        last_active = (st_r.row == {1'b0, cfg.rows} - 13'd1);
        next_active = row_last || (st_r.row + 13'd1 < {1'b0, cfg.rows});
    end

    // ------------------------------------------------------------------
    // Embedded sync in line blanking
    // ------------------------------------------------------------------
    // End code leads the blanking; start code for the next row closes it,
    // so with blanking of at least 8 the two fields never overlap
    always_comb begin
        sync_end = cfg.embed && row_active && in_line_blank_interval && (hpos < spof_pkg::SPOF_SYNC_LEN);
        sync_start = cfg.embed && in_line_blank_interval && next_active &&
                     (hpos >= {1'b0, cfg.line_blank_interval} - spof_pkg::SPOF_SYNC_LEN);
        if (sync_end) begin
            sync_idx = hpos[1:0];
        end else begin
            sync_idx = 2'(hpos - ({1'b0, cfg.line_blank_interval} - spof_pkg::SPOF_SYNC_LEN));
        end
        case (sync_idx)
            2'd0: sync_word = spof_pkg::SPOF_SYNC_PREFIX;
            2'd1: sync_word = spof_pkg::SPOF_SYNC_ZERO;
            2'd2: sync_word = spof_pkg::SPOF_SYNC_ZERO;
            default: begin
                if (sync_end && last_active) begin
                    sync_word = spof_pkg::SPOF_CODE_FRAME_END;
                end else if (sync_end) begin
                    sync_word = spof_pkg::SPOF_CODE_ROW_END;
                end else if (row_last) begin
                    sync_word = spof_pkg::SPOF_CODE_FRAME_START;
                end else begin
                    sync_word = spof_pkg::SPOF_CODE_ROW_START;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Pixel word formatting
    // ------------------------------------------------------------------
    always_comb begin
        pix8 = raw_pixel[11:4];
        if (cfg.embed && !cfg.width12 && pix8 == spof_pkg::SPOF_SYNC_PREFIX) begin
            pix8 = spof_pkg::SPOF_PIX_REMAP;
        end
        bus_val = 12'h000;
        if ((sync_end || sync_start) && cfg.downshift) begin
            bus_val = {4'h0, sync_word};
        end else if (sync_end || sync_start) begin
            bus_val = {sync_word, 4'h0};
        end else if (valid) begin
            if (cfg.width12 && cfg.downshift) begin
                bus_val = {4'h0, raw_pixel[11:4]};
            end else if (cfg.width12) begin
                bus_val = raw_pixel;
            end else if (cfg.downshift) begin
                bus_val = {4'h0, pix8};
            end else begin
                bus_val = {pix8, 4'h0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Sync and strobe levels
    // ------------------------------------------------------------------
    // Syncs are driven from timing alone, so embedded codes never silence them
    always_comb begin
        frame_lvl = row_active;
        if (cfg.dv_mode) begin
            line_lvl = valid;
        end else begin
            line_lvl = !in_line_blank_interval;
        end
        // Image data only ever leaves while both levels are high
        if (!frame_lvl) begin
            line_lvl = cfg.dv_mode ? 1'b0 : line_lvl;
        end
        // In data-valid signalling, mode 11 trades receiver work for a clock that never stops
        if (!cfg.dv_mode) begin
            strobe_lvl = valid;
        end else begin
            case (cfg.strobe_mode)
                spof_pkg::SPOF_STB_ROW: strobe_lvl = row_active;
                spof_pkg::SPOF_STB_QUAL: strobe_lvl = valid;
                spof_pkg::SPOF_STB_NOINV: strobe_lvl = row_active && (in_line_blank_interval || valid);
                spof_pkg::SPOF_STB_ALL: strobe_lvl = 1'b1;
                default: strobe_lvl = valid;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bayer colour tag
    // ------------------------------------------------------------------
    // Dark slots count as column 0, so a dark run shows a single colour
    always_comb begin
        col_odd = in_dark ? 1'b0 : col[0];
        if (!valid) begin
            colour_val = spof_pkg::SPOF_COL_GREEN;
        end else if (st_r.row[0] == col_odd) begin
            colour_val = spof_pkg::SPOF_COL_GREEN;
        end else if (st_r.row[0]) begin
            colour_val = spof_pkg::SPOF_COL_BLUE;
        end else begin
            colour_val = spof_pkg::SPOF_COL_RED;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Counters never restart on a config write, so a mid-line change gives one odd line
        if (slot_last) begin
            st_nxt.slot = 13'd0;
            if (row_last) begin
                st_nxt.row = 13'd0;
                st_nxt.frame_cnt = st_r.frame_cnt + 12'h001;
            end else begin
                st_nxt.row = st_r.row + 13'd1;
            end
        end else begin
            st_nxt.slot = st_r.slot + 13'd1;
        end
        st_nxt.pixel_bus = bus_val;
        st_nxt.line_sync = line_lvl ^ cfg.inv_line;
        st_nxt.frame_sync = frame_lvl ^ cfg.inv_frame;
        st_nxt.pixel_strobe = strobe_lvl ^ cfg.inv_strobe;
        st_nxt.colour = colour_val;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{slot: 13'd0,
                      row: 13'd0,
                      frame_cnt: 12'h000,
                      pixel_bus: 12'h000,
                      line_sync: 1'b0,
                      frame_sync: 1'b0,
                      pixel_strobe: 1'b0,
                      colour: spof_pkg::SPOF_COL_GREEN};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and status
    // ------------------------------------------------------------------
    assign pixel_bus = st_r.pixel_bus;
    assign line_sync = st_r.line_sync;
    assign frame_sync = st_r.frame_sync;
    assign pixel_strobe = st_r.pixel_strobe;
    assign pixel_colour = st_r.colour;

    always_comb begin
        status.row = st_r.row[11:0];
        status.frame_cnt = st_r.frame_cnt;
        status.in_frame_blank_rows = !row_active;
    end
endmodule
`default_nettype wire

/* File: hdl/spof_pkg.sv */
// Shared constants and carrier types of the sensor pixel output formatter.
// Assumes one clock domain; every field position and reset value lives here.
package spof_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] SPOF_OFS_CTRL = 8'h00;
    localparam logic [7:0] SPOF_OFS_DECIM = 8'h04;
    localparam logic [7:0] SPOF_OFS_HTIME = 8'h08;
    localparam logic [7:0] SPOF_OFS_VTIME = 8'h0C;
    localparam logic [7:0] SPOF_OFS_STATUS = 8'h10;

    // CTRL bit positions
    localparam int SPOF_CTRL_WIDTH12 = 0;
    localparam int SPOF_CTRL_DOWNSHIFT = 1;
    localparam int SPOF_CTRL_EMBED = 2;
    localparam int SPOF_CTRL_DVMODE = 3;
    localparam int SPOF_CTRL_STROBE_LSB = 4;
    localparam int SPOF_CTRL_INV_LINE = 6;
    localparam int SPOF_CTRL_INV_FRAME = 7;
    localparam int SPOF_CTRL_INV_STROBE = 8;
    localparam int SPOF_CTRL_DARK_OUT = 9;
    localparam int SPOF_CTRL_ALL_PHYS = 10;
    localparam int SPOF_CTRL_BLACK_ROWS = 11;
    // DECIM, HTIME, VTIME and STATUS field positions
    localparam int SPOF_DEC_SUBC_LSB = 0;
    localparam int SPOF_DEC_SUBR_LSB = 4;
    localparam int SPOF_DEC_BINC_LSB = 8;
    localparam int SPOF_DEC_BINR_LSB = 12;
    localparam int SPOF_TIME_ACT_LSB = 0;
    localparam int SPOF_TIME_BLANK_LSB = 16;
    localparam int SPOF_STAT_ROW_LSB = 0;
    localparam int SPOF_STAT_FRAME_LSB = 16;
    localparam int SPOF_STAT_FRAME_BLANK_ROWS = 31;

    // Reset values: 12-bit, data-valid signalling, strobe mode 10, full array
    localparam logic [31:0] SPOF_CTRL_RST = 32'h0000_0029;
    localparam logic [31:0] SPOF_DECIM_RST = 32'h0000_1111;
    localparam logic [31:0] SPOF_HTIME_RST = 32'h0010_0820;
    localparam logic [31:0] SPOF_VTIME_RST = 32'h0008_0620;
    // Writable bits of each register; the rest read as zero
    localparam logic [31:0] SPOF_CTRL_MASK = 32'h0000_0FFF;
    localparam logic [31:0] SPOF_DECIM_MASK = 32'h0000_7777;
    localparam logic [31:0] SPOF_TIME_MASK = 32'h0FFF_0FFF;

    // ------------------------------------------------------------------
    // Array geometry and embedded sync words
    // ------------------------------------------------------------------
    localparam logic [12:0] SPOF_DARK_SLOTS = 13'h0018;
    localparam logic [11:0] SPOF_BORDER = 12'h00C;
    localparam logic [11:0] SPOF_LINE_BLANK_INTERVAL_MIN = 12'h008;
    localparam logic [12:0] SPOF_SYNC_LEN = 13'h0004;
    localparam logic [7:0] SPOF_SYNC_PREFIX = 8'hFF;
    localparam logic [7:0] SPOF_SYNC_ZERO = 8'h00;
    localparam logic [7:0] SPOF_PIX_REMAP = 8'hFE;
    localparam logic [7:0] SPOF_CODE_ROW_START = 8'h00;
    localparam logic [7:0] SPOF_CODE_ROW_END = 8'h01;
    localparam logic [7:0] SPOF_CODE_FRAME_START = 8'h02;
    localparam logic [7:0] SPOF_CODE_FRAME_END = 8'h03;
    // Pixel strobe modes
    localparam logic [1:0] SPOF_STB_ROW = 2'b00;
    localparam logic [1:0] SPOF_STB_QUAL = 2'b01;
    localparam logic [1:0] SPOF_STB_NOINV = 2'b10;
    localparam logic [1:0] SPOF_STB_ALL = 2'b11;
    // Colour tags on pixel_colour
    localparam logic [1:0] SPOF_COL_GREEN = 2'b00;
    localparam logic [1:0] SPOF_COL_RED = 2'b01;
    localparam logic [1:0] SPOF_COL_BLUE = 2'b10;

    typedef struct packed {
        logic width12;
        logic downshift;
        logic embed;
        logic dv_mode;
        logic [1:0] strobe_mode;
        logic inv_line;
        logic inv_frame;
        logic inv_strobe;
        logic dark_out;
        logic all_phys;
        logic black_rows;
        logic [3:0] sub_col;
        logic [3:0] sub_row;
        logic [2:0] bin_col;
        logic [2:0] bin_row;
        logic [11:0] cols;
        logic [11:0] line_blank_interval;
        logic [11:0] rows;
        logic [11:0] frame_blank_rows;
    } spof_cfg_t;

    typedef struct packed {
        logic [11:0] row;
        logic [11:0] frame_cnt;
        logic in_frame_blank_rows;
    } spof_status_t;

    typedef struct packed {
        logic half;
        logic [3:0] phase;
    } spof_keep_state_t;

endpackage

/* File: hdl/spof_pair_keep.sv */
// Bayer pair decimator: passes one pair out of every period pairs.
// Assumes step marks each element and restart comes before the first one.
`timescale 1ns/10ps
`default_nettype none
module spof_pair_keep (
    input wire logic clk,
    input wire logic rstn,
    input wire logic restart,
    input wire logic step,
    input wire logic [3:0] period,
    output logic keep
);
    spof_pkg::spof_keep_state_t st_r;
    spof_pkg::spof_keep_state_t st_nxt;

    // Phase only moves after the second element of a pair, keeping colour order
    always_comb begin
        st_nxt = st_r;
        if (restart) begin
            st_nxt = '0;
        end else if (step) begin
            st_nxt.half = ~st_r.half;
            if (st_r.half) begin
                if (st_r.phase + 4'h1 >= period) begin
                    st_nxt.phase = 4'h0;
                end else begin
                    st_nxt.phase = st_r.phase + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign keep = (st_r.phase == 4'h0);
endmodule
`default_nettype wire

/* File: hdl/spof_apb_regs.sv */
// APB register file of the formatter: configuration out, status in.
// Assumes an APB master; one access phase per transfer, all answers registered.
`timescale 1ns/10ps
`default_nettype none
module spof_apb_regs (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire spof_pkg::spof_status_t status,
    output spof_pkg::spof_cfg_t cfg
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] decim;
        logic [31:0] htime;
        logic [31:0] vtime;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } spof_regs_t;

    spof_regs_t st_r;
    spof_regs_t st_nxt;
    logic [31:0] rd;
    logic hit;
    logic [31:0] hw;

    always_comb begin
        st_nxt = st_r;
        rd = 32'h0000_0000;
        hit = 1'b1;
        hw = pwdata & spof_pkg::SPOF_TIME_MASK;
        // Too short a blanking would not hold two sync fields
        if (hw[spof_pkg::SPOF_TIME_BLANK_LSB +: 12] < spof_pkg::SPOF_LINE_BLANK_INTERVAL_MIN) begin
            hw[spof_pkg::SPOF_TIME_BLANK_LSB +: 12] = spof_pkg::SPOF_LINE_BLANK_INTERVAL_MIN;
        end
        case (paddr)
            spof_pkg::SPOF_OFS_CTRL: rd = st_r.ctrl;
            spof_pkg::SPOF_OFS_DECIM: rd = st_r.decim;
            spof_pkg::SPOF_OFS_HTIME: rd = st_r.htime;
            spof_pkg::SPOF_OFS_VTIME: rd = st_r.vtime;
            spof_pkg::SPOF_OFS_STATUS: begin
                rd[spof_pkg::SPOF_STAT_ROW_LSB +: 12] = status.row;
                rd[spof_pkg::SPOF_STAT_FRAME_LSB +: 12] = status.frame_cnt;
                rd[spof_pkg::SPOF_STAT_FRAME_BLANK_ROWS] = status.in_frame_blank_rows;
            end
            default: hit = 1'b0;
        endcase
        // Answer is prepared in the setup cycle and shown in the access cycle
        st_nxt.pready = psel & ~penable;
        if (psel && !penable) begin
            st_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
            st_nxt.pslverr = ~hit;
        end
        if (psel && penable && st_r.pready && pwrite) begin
            case (paddr)
                spof_pkg::SPOF_OFS_CTRL: st_nxt.ctrl = pwdata & spof_pkg::SPOF_CTRL_MASK;
                spof_pkg::SPOF_OFS_DECIM: st_nxt.decim = pwdata & spof_pkg::SPOF_DECIM_MASK;
                spof_pkg::SPOF_OFS_HTIME: st_nxt.htime = hw;
                spof_pkg::SPOF_OFS_VTIME: st_nxt.vtime = pwdata & spof_pkg::SPOF_TIME_MASK;
                default: st_nxt.ctrl = st_r.ctrl;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{ctrl: spof_pkg::SPOF_CTRL_RST, decim: spof_pkg::SPOF_DECIM_RST,
                      htime: spof_pkg::SPOF_HTIME_RST, vtime: spof_pkg::SPOF_VTIME_RST,
                      prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;

    always_comb begin
        cfg.width12 = st_r.ctrl[spof_pkg::SPOF_CTRL_WIDTH12];
        cfg.downshift = st_r.ctrl[spof_pkg::SPOF_CTRL_DOWNSHIFT];
        cfg.embed = st_r.ctrl[spof_pkg::SPOF_CTRL_EMBED];
        cfg.dv_mode = st_r.ctrl[spof_pkg::SPOF_CTRL_DVMODE];
        cfg.strobe_mode = st_r.ctrl[spof_pkg::SPOF_CTRL_STROBE_LSB +: 2];
        cfg.inv_line = st_r.ctrl[spof_pkg::SPOF_CTRL_INV_LINE];
        cfg.inv_frame = st_r.ctrl[spof_pkg::SPOF_CTRL_INV_FRAME];
        cfg.inv_strobe = st_r.ctrl[spof_pkg::SPOF_CTRL_INV_STROBE];
        cfg.dark_out = st_r.ctrl[spof_pkg::SPOF_CTRL_DARK_OUT];
        cfg.all_phys = st_r.ctrl[spof_pkg::SPOF_CTRL_ALL_PHYS];
        cfg.black_rows = st_r.ctrl[spof_pkg::SPOF_CTRL_BLACK_ROWS];
        cfg.sub_col = st_r.decim[spof_pkg::SPOF_DEC_SUBC_LSB +: 4];
        cfg.sub_row = st_r.decim[spof_pkg::SPOF_DEC_SUBR_LSB +: 4];
        cfg.bin_col = st_r.decim[spof_pkg::SPOF_DEC_BINC_LSB +: 3];
        cfg.bin_row = st_r.decim[spof_pkg::SPOF_DEC_BINR_LSB +: 3];
        cfg.cols = st_r.htime[spof_pkg::SPOF_TIME_ACT_LSB +: 12];
        cfg.line_blank_interval = st_r.htime[spof_pkg::SPOF_TIME_BLANK_LSB +: 12];
        cfg.rows = st_r.vtime[spof_pkg::SPOF_TIME_ACT_LSB +: 12];
        cfg.frame_blank_rows = st_r.vtime[spof_pkg::SPOF_TIME_BLANK_LSB +: 12];
    end
endmodule
`default_nettype wire

/* File: bench/spof_properties.sv */
// Port checks of the formatter.
// Assumes CTRL changes only by APB.
`timescale 1ns/10ps
`default_nettype none
module spof_properties (
    input wire logic clk, rstn, psel, penable, pwrite, pready,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [11:0] pixel_bus,
    input wire logic line_sync, frame_sync, pixel_strobe,
    input wire logic [1:0] pixel_colour
);
    logic [11:0] c_r, c_d;
    logic dv, e8;
    // Outputs lag a CTRL write by one slot, as c_d does
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {c_r, c_d} <= {2{12'h029}};
        end else begin
            c_d <= c_r;
            if (psel && penable && pready && pwrite && paddr == 8'h00) c_r <= pwdata[11:0];
        end
    end
    assign dv = c_d[3] && c_d[7:6] == 2'h0;
    assign e8 = c_d[2:0] == 3'h4;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_zero; pixel_bus[11:4] == 8'h00 [*2]; endsequence
    sequence s_code; pixel_bus[11:4] <= 8'h03; endsequence
    AST_APB: assert property (psel && !penable |=> pready) else $error("no ready");
    AST_PULSE: assert property (pready |=> !pready) else $error("ready held");
    AST_SYNC: assert property (e8 && pixel_bus[11:4] == 8'hFF |=> s_zero ##1 s_code)
        else $error("sync");
    AST_REMAP: assert property (e8 && dv && line_sync |-> pixel_bus[11:4] != 8'hFF)
        else $error("remap");
    AST_BLANK: assert property (e8 && dv && pixel_bus[11:4] == 8'hFF |-> !line_sync [*4])
        else $error("blank");
    AST_FRAME: assert property (dv && line_sync |-> frame_sync)
        else $error("frame");
    AST_QUAL: assert property (dv && c_d[8:4] == 5'h01 && pixel_strobe |-> line_sync)
        else $error("qual");
    AST_ALL: assert property (c_d[5:3] == 3'h7 |-> pixel_strobe != c_d[8])
        else $error("strobe");
    AST_COLOUR: assert property (dv && !c_d[9] && line_sync |=> !line_sync || $changed(pixel_colour == 2'h0))
        else $error("colour");
    AST_SHIFT: assert property (c_d[1] && dv && line_sync |-> pixel_bus[11:8] == 4'h0)
        else $error("shift");
    AST_UPPER: assert property (c_d[1:0] == 2'h0 && dv && line_sync |-> pixel_bus[3:0] == 4'h0)
        else $error("upper");
endmodule
bind spof_formatter spof_properties u_props (.clk, .rstn, .psel, .penable, .pwrite, .pready, .paddr,
    .pwdata, .pixel_bus, .line_sync, .frame_sync, .pixel_strobe, .pixel_colour);
`default_nettype wire

/* File: bench/spof_receiver.sv */
// Back-end receiver: counts valid words per frame.
`timescale 1ns/10ps
`default_nettype none
module spof_receiver (
    input wire logic clk, rstn, line_sync, frame_sync, pixel_strobe,
    output logic [15:0] words,
    output logic done
);
    logic [15:0] cnt;
    logic fs_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {cnt, words, done, fs_q} <= '0;
        end else begin
            fs_q <= frame_sync;
            done <= fs_q && !frame_sync;
            words <= done ? words : cnt;
            cnt <= (fs_q && !frame_sync) ? 16'h0 : cnt + 16'(pixel_strobe && line_sync);
        end
    end
endmodule
`default_nettype wire

/* File: bench/sensor_pixel_output_formatter_tb_top.sv */
// Bench: APB checks and word counts of 16x4 frames.
// Assumes the receiver model counts strobed valid words per frame.
`timescale 1ns/10ps
`default_nettype none
module sensor_pixel_output_formatter_tb_top;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, line_sync, frame_sync, pixel_strobe, done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [11:0] raw_pixel, pixel_bus;
    logic [15:0] words;
    logic [32:0] rq[$];
    logic [15:0] fq[$];
    int err_total = 0, comparisons = 0;
    // CTRL, DECIM, words per frame
    logic [43:0] tbl[11] = '{44'h419_1111_0040, 44'h419_1112_0020, 44'h419_1121_0020, 44'h419_1211_0020,
        44'h419_1311_0018, 44'h419_1411_0010, 44'h61C_1111_00A0, 44'h429_1111_0040, 44'h539_1111_0000,
        44'h401_1111_0040, 44'h40B_1111_0040};
    spof_formatter u_dut (.clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .raw_pixel, .pixel_bus, .line_sync, .frame_sync, .pixel_strobe, .pixel_colour());
    spof_receiver u_rx (.clk, .rstn, .line_sync, .frame_sync, .pixel_strobe, .words, .done);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Frequent full-scale samples keep the 8-bit remap busy
    initial begin
        void'($urandom(19161));
        forever @(posedge clk) raw_pixel <= $urandom_range(3) == 0 ? 12'hFFF : 12'($urandom);
    end
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata} === rq.pop_front());
        if (done === 1'b1 && fq.size() > 0) check(words === fq.pop_front());
    end
    task automatic check(input logic ok);
        comparisons++;
        if (!ok) begin
            err_total++;
            $display("unexpected result at %0t", $time);
        end
    endtask
    task automatic print_verdict;
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic give_up(input int n);
        if (n >= 1000) begin
            err_total++;
            print_verdict;
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        {paddr, pwrite, pwdata, psel} <= {a, w, d, 1'b1};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 1000);
        {psel, penable} <= 2'h0;
        @(posedge clk);
        give_up(n);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask
    task automatic wait_done;
        int n = 0;
        do @(posedge clk); while (done !== 1'b1 && ++n < 1000);
        give_up(n);
    endtask
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(8'h00, 33'h0_0000_0029);
        rd(8'h14, 33'h1_0000_0000);
        apb(8'h08, 1'b1, 32'h0004_0010);
        rd(8'h08, 33'h0_0008_0010);
        apb(8'h0C, 1'b1, 32'h0002_0004);
        apb(8'h00, 1'b1, 32'hFFFF_F419);
        rd(8'h00, 33'h0_0000_0419);
        foreach (tbl[i]) begin
            apb(8'h00, 1'b1, {20'h0, tbl[i][43:32]});
            apb(8'h04, 1'b1, {16'h0, tbl[i][31:16]});
            wait_done;
            @(negedge clk);
            fq.push_back(tbl[i][15:0]);
            wait_done;
        end
        print_verdict;
    end
endmodule
`default_nettype wire
